// *** uoec_assertions.sv ***
// Concurrent checks on the OUT endpoint control ports
`timescale 1ns/10ps
module uoec_assertions #(
    parameter int CW = 11
) (
    input wire logic               mclk,
    input wire logic               nrst,
    input wire logic [7:0]         reg_addr,
    input wire logic [7:0]         reg_wdata,
    input wire logic               reg_wr,
    input wire logic               reg_rd,
    input wire logic [7:0]         reg_rdata,
    input wire logic               rx_done,
    input wire logic [CW-1:0]      rx_len,
    input wire logic               rx_crc_err,
    input wire logic               hs_valid,
    input wire uoec_pkg::uoec_hs_t hs_code,
    input wire logic               fifo_keep,
    input wire logic               fifo_drop,
    input wire logic               fifo_flush,
    input wire logic               clear_toggle,
    input wire logic               ep_irq
);
    // ------------------------------------------------------------
    // Mode and stall shadows
    // ------------------------------------------------------------
    logic iso_q;
    logic stall_q;
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            iso_q   <= 1'b0;
            stall_q <= 1'b0;
        end else if (reg_wr && reg_addr == uoec_pkg::OFF_CTRL_HIGH) begin
            iso_q <= reg_wdata[uoec_pkg::BIT_ISO];
        end else if (reg_wr && reg_addr == uoec_pkg::OFF_CTRL_LOW) begin
            stall_q <= reg_wdata[uoec_pkg::BIT_SEND_STALL];
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    a_keep_or_drop: assert property (rx_done |=> fifo_keep != fifo_drop)
        else $error("packet neither kept nor dropped once");
    a_no_stray_result: assert property (!rx_done |=> !hs_valid && !fifo_keep && !fifo_drop)
        else $error("packet result without packet");
    a_stall_reply: assert property (rx_done && !iso_q && stall_q |=> hs_valid && ep_irq
        && hs_code == uoec_pkg::UOEC_HS_STALL && fifo_drop)
        else $error("stall reply wrong");
    a_iso_silent: assert property (rx_done && iso_q |=> !hs_valid && ep_irq)
        else $error("iso packet reply wrong");
    a_bulk_crc_drop: assert property (rx_done && !iso_q && !stall_q && rx_crc_err
        |=> !hs_valid && fifo_drop && !ep_irq)
        else $error("bulk crc packet not dropped quietly");
    a_ack_keep: assert property (hs_valid && hs_code == uoec_pkg::UOEC_HS_ACK |-> fifo_keep && ep_irq)
        else $error("ack without keep and irq");
    a_nak_drop: assert property (hs_valid && hs_code == uoec_pkg::UOEC_HS_NAK |-> fifo_drop && !ep_irq)
        else $error("nak without drop");
    a_code_idle: assert property (!hs_valid |-> hs_code == uoec_pkg::UOEC_HS_NONE)
        else $error("handshake code outside valid");
    a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("read data without read");
    a_flush_pulse: assert property (reg_wr && reg_addr == uoec_pkg::OFF_CTRL_LOW
        && reg_wdata[uoec_pkg::BIT_FLUSH] |=> fifo_flush)
        else $error("flush pulse missing");
    a_no_stray_ctrl: assert property (!reg_wr |=> !fifo_flush && !clear_toggle)
        else $error("control pulse without write");
endmodule // uoec_assertions

bind uoec_ctrl uoec_assertions #(.CW(CW)) u_chk (
    .mclk(mclk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_done(rx_done),
    .rx_len(rx_len), .rx_crc_err(rx_crc_err), .hs_valid(hs_valid), .hs_code(hs_code),
    .fifo_keep(fifo_keep), .fifo_drop(fifo_drop), .fifo_flush(fifo_flush),
    .clear_toggle(clear_toggle), .ep_irq(ep_irq)
);

// *** uoec_ctrl.sv ***
// OUT endpoint control: packet-ready handshake, stall, overrun, data error
//
// Added by the designer: the plain strobed port and the address map.
`timescale 1ns/10ps
module uoec_ctrl #(
    parameter int CW = uoec_pkg::CNT_W
) (
    input  wire logic                mclk,
    input  wire logic                nrst,
    // Register port
    input  wire logic [7:0]          reg_addr,
    input  wire logic [7:0]          reg_wdata,
    input  wire logic                reg_wr,
    input  wire logic                reg_rd,
    output logic      [7:0]          reg_rdata,
    // Packet side from the USB receiver
    input  wire logic                rx_done,
    input  wire logic [CW-1:0]       rx_len,
    input  wire logic                rx_crc_err,
    // Packet side results
    output logic                     hs_valid,
    output uoec_pkg::uoec_hs_t       hs_code,
    output logic                     fifo_keep,
    output logic                     fifo_drop,
    output logic                     fifo_flush,
    output logic                     clear_toggle,
    output logic                     ep_irq
);

    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    uoec_slot_if #(.CW(CW)) sif ();

    logic               send_stall_q;
    logic               send_stall_d;
    logic               stall_sent_q;
    logic               stall_sent_d;
    logic               overrun_q;
    logic               overrun_d;
    logic               dbuf_en_q;
    logic               dbuf_en_d;
    logic               iso_q;
    logic               iso_d;
    logic               ready_q;
    logic [7:0]         rdata_q;
    logic [7:0]         rdata_d;
    logic               irq_q;
    logic               irq_d;
    logic               hs_valid_q;
    logic               hs_valid_d;
    uoec_pkg::uoec_hs_t hs_code_q;
    uoec_pkg::uoec_hs_t hs_code_d;
    logic               keep_q;
    logic               keep_d;
    logic               drop_q;
    logic               drop_d;
    logic               flush_q;
    logic               flush_d;
    logic               clear_toggle_bit_q;
    logic               clear_toggle_bit_d;

    logic               wr_low;
    logic               wr_high;
    logic               rd_hit;
    logic               stall_now;
    logic               take_pkt;
    logic               no_room;
    logic               refill;
    logic [7:0]         low_view;
    logic [15:0]        cnt_view;

    // ------------------------------------------------------------
    // Slot store
    // ------------------------------------------------------------
    uoec_slots #(.CW(CW)) u_slots (
        .mclk (mclk),
        .nrst (nrst),
        .sif  (sif)
    );

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        return a == off;
    endfunction

    always_comb begin
        wr_low  = reg_wr && hit(reg_addr, uoec_pkg::OFF_CTRL_LOW);
        wr_high = reg_wr && hit(reg_addr, uoec_pkg::OFF_CTRL_HIGH);
        rd_hit  = 1'b0;
        if (hit(reg_addr, uoec_pkg::OFF_CTRL_LOW)) begin
            rd_hit = 1'b1;
        end else if (hit(reg_addr, uoec_pkg::OFF_CTRL_HIGH)) begin
            rd_hit = 1'b1;
        end else if (hit(reg_addr, uoec_pkg::OFF_CNT_LOW)) begin
            rd_hit = 1'b1;
        end else if (hit(reg_addr, uoec_pkg::OFF_CNT_HIGH)) begin
            rd_hit = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Packet reception
    // ------------------------------------------------------------
    always_comb begin
        no_room    = sif.full && !sif.pop;
        stall_now  = rx_done && !iso_q && send_stall_q;
        take_pkt   = 1'b0;
        hs_valid_d = 1'b0;
        hs_code_d  = uoec_pkg::UOEC_HS_NONE;
        keep_d     = 1'b0;
        drop_d     = 1'b0;
        if (rx_done) begin
            if (iso_q) begin
                // No handshake in isochronous mode
                take_pkt = !no_room;
                keep_d   = !no_room;
                drop_d   = no_room;
            end else if (send_stall_q) begin
                // Same path for bulk and interrupt
                hs_valid_d = 1'b1;
                hs_code_d  = uoec_pkg::UOEC_HS_STALL;
                drop_d     = 1'b1;
            end else if (rx_crc_err) begin
                drop_d = 1'b1;
            end else if (no_room) begin
                hs_valid_d = 1'b1;
                hs_code_d  = uoec_pkg::UOEC_HS_NAK;
                drop_d     = 1'b1;
            end else begin
                take_pkt   = 1'b1;
                hs_valid_d = 1'b1;
                hs_code_d  = uoec_pkg::UOEC_HS_ACK;
                keep_d     = 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Slot control
    // ------------------------------------------------------------
    always_comb begin
        ready_q      = sif.count != 2'h0;
        sif.push     = take_pkt;
        sif.push_len = rx_len;
        sif.push_err = iso_q && rx_crc_err;
        sif.pop      = wr_low && !reg_wdata[uoec_pkg::BIT_PKT_READY]
                       && ready_q;
        sif.flush    = wr_low && reg_wdata[uoec_pkg::BIT_FLUSH];
        sif.dbuf_en  = dbuf_en_q;
        // Flush empties both slots, so no second packet follows
        refill       = sif.pop && !sif.flush && (sif.count == 2'h2);
        flush_d      = sif.flush;
        clear_toggle_bit_d      = wr_low && reg_wdata[uoec_pkg::BIT_CLEAR_TOGGLE];
    end

    // ------------------------------------------------------------
    // Control and status flags
    // ------------------------------------------------------------
    always_comb begin
        send_stall_d = send_stall_q;
        dbuf_en_d    = dbuf_en_q;
        iso_d        = iso_q;
        if (wr_low) begin
            send_stall_d = reg_wdata[uoec_pkg::BIT_SEND_STALL];
        end
        if (wr_high) begin
            dbuf_en_d = reg_wdata[uoec_pkg::BIT_DBUF_EN];
            iso_d     = reg_wdata[uoec_pkg::BIT_ISO];
        end
        // Hardware set wins over a clearing write
        stall_sent_d = stall_now ||
                       (stall_sent_q &&
                        !(wr_low && !reg_wdata[uoec_pkg::BIT_STALL_SENT]));
        overrun_d    = (rx_done && iso_q && no_room) ||
                       (overrun_q &&
                        !(wr_low && !reg_wdata[uoec_pkg::BIT_OVERRUN]));
        irq_d        = take_pkt || refill || stall_now ||
                       (rx_done && iso_q && no_room);
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    always_comb begin
        low_view = 8'h00;
        low_view[uoec_pkg::BIT_STALL_SENT] = stall_sent_q;
        low_view[uoec_pkg::BIT_SEND_STALL] = send_stall_q;
        low_view[uoec_pkg::BIT_DATA_ERROR] = ready_q && sif.head_err;
        low_view[uoec_pkg::BIT_OVERRUN]    = overrun_q;
        low_view[uoec_pkg::BIT_FIFO_FULL]  = sif.full;
        low_view[uoec_pkg::BIT_PKT_READY]  = ready_q;
        cnt_view = ready_q ? 16'(sif.head_len) : 16'h0000;
        rdata_d  = 8'h00;
        if (reg_rd && rd_hit) begin
            if (hit(reg_addr, uoec_pkg::OFF_CTRL_LOW)) begin
                rdata_d = low_view;
            end else if (hit(reg_addr, uoec_pkg::OFF_CTRL_HIGH)) begin
                rdata_d[uoec_pkg::BIT_DBUF_EN] = dbuf_en_q;
                rdata_d[uoec_pkg::BIT_ISO]     = iso_q;
            end else if (hit(reg_addr, uoec_pkg::OFF_CNT_LOW)) begin
                rdata_d = cnt_view[7:0];
            end else begin
                rdata_d = cnt_view[15:8];
            end
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            send_stall_q <= uoec_pkg::RST_CTRL_LOW[uoec_pkg::BIT_SEND_STALL];
            stall_sent_q <= uoec_pkg::RST_CTRL_LOW[uoec_pkg::BIT_STALL_SENT];
            overrun_q    <= uoec_pkg::RST_CTRL_LOW[uoec_pkg::BIT_OVERRUN];
            dbuf_en_q    <= uoec_pkg::RST_CTRL_HIGH[uoec_pkg::BIT_DBUF_EN];
            iso_q        <= uoec_pkg::RST_CTRL_HIGH[uoec_pkg::BIT_ISO];
            rdata_q      <= 8'h00;
            irq_q        <= 1'b0;
            hs_valid_q   <= 1'b0;
            hs_code_q    <= uoec_pkg::UOEC_HS_NONE;
            keep_q       <= 1'b0;
            drop_q       <= 1'b0;
            flush_q      <= 1'b0;
            clear_toggle_bit_q      <= 1'b0;
        end else begin
            send_stall_q <= send_stall_d;
            stall_sent_q <= stall_sent_d;
            overrun_q    <= overrun_d;
            dbuf_en_q    <= dbuf_en_d;
            iso_q        <= iso_d;
            rdata_q      <= rdata_d;
            irq_q        <= irq_d;
            hs_valid_q   <= hs_valid_d;
            hs_code_q    <= hs_code_d;
            keep_q       <= keep_d;
            drop_q       <= drop_d;
            flush_q      <= flush_d;
            clear_toggle_bit_q      <= clear_toggle_bit_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign reg_rdata    = rdata_q;
    assign hs_valid     = hs_valid_q;
    assign hs_code      = hs_code_q;
    assign fifo_keep    = keep_q;
    assign fifo_drop    = drop_q;
    assign fifo_flush   = flush_q;
    assign clear_toggle = clear_toggle_bit_q;
    assign ep_irq       = irq_q;

endmodule // uoec_ctrl

// *** uoec_host_model.sv ***
// Behavioural USB host delivering OUT packets to the endpoint
`timescale 1ns/10ps
module uoec_host_model #(
    parameter int CW = 11
) (
    input  wire logic          mclk,
    output logic               rx_done,
    output logic [CW-1:0]      rx_len,
    output logic               rx_crc_err
);
    initial begin
        rx_done    = 1'b0;
        rx_len     = '0;
        rx_crc_err = 1'b0;
    end
    // One OUT token with data, any spacing
    task automatic pkt(input logic [CW-1:0] len, input logic crc);
        @(posedge mclk);
        rx_done    <= 1'b1;
        rx_len     <= len;
        rx_crc_err <= crc;
    endtask
    // Idle bus, stale fields inverted
    task automatic idle();
        @(posedge mclk);
        rx_done    <= 1'b0;
        rx_len     <= ~rx_len;
        rx_crc_err <= ~rx_crc_err;
    endtask
endmodule // uoec_host_model

// *** uoec_pkg.sv ***
// Shared constants and types for the OUT endpoint control block
package uoec_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_CTRL_LOW  = 8'h00;
    localparam logic [7:0] OFF_CTRL_HIGH = 8'h01;
    localparam logic [7:0] OFF_CNT_LOW   = 8'h02;
    localparam logic [7:0] OFF_CNT_HIGH  = 8'h03;

    // ------------------------------------------------------------
    // Control low bit positions
    // ------------------------------------------------------------
    localparam int BIT_CLEAR_TOGGLE = 7;
    localparam int BIT_STALL_SENT   = 6;
    localparam int BIT_SEND_STALL   = 5;
    localparam int BIT_FLUSH        = 4;
    localparam int BIT_DATA_ERROR   = 3;
    localparam int BIT_OVERRUN      = 2;
    localparam int BIT_FIFO_FULL    = 1;
    localparam int BIT_PKT_READY    = 0;

    // ------------------------------------------------------------
    // Control high bit positions
    // ------------------------------------------------------------
    localparam int BIT_DBUF_EN = 7;
    localparam int BIT_ISO     = 6;

    // ------------------------------------------------------------
    // Reset values and sizes
    // ------------------------------------------------------------
    localparam logic [7:0] RST_CTRL_LOW  = 8'h00;
    localparam logic [7:0] RST_CTRL_HIGH = 8'h00;
    localparam int         CNT_W         = 11;
    localparam int         SLOTS         = 2;

    // ------------------------------------------------------------
    // Handshake answers
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        UOEC_HS_NONE  = 2'b00,
        UOEC_HS_ACK   = 2'b01,
        UOEC_HS_NAK   = 2'b10,
        UOEC_HS_STALL = 2'b11
    } uoec_hs_t;

endpackage

// *** uoec_slot_if.sv ***
// Interface between the endpoint control and its packet slot store
`timescale 1ns/10ps
interface uoec_slot_if #(parameter int CW = 11);
    logic          push;
    logic [CW-1:0] push_len;
    logic          push_err;
    logic          pop;
    logic          flush;
    logic          dbuf_en;
    logic [1:0]    count;
    logic          full;
    logic [CW-1:0] head_len;
    logic          head_err;

    modport ctrl  (output push, push_len, push_err, pop, flush, dbuf_en,
                   input  count, full, head_len, head_err);
    modport store (input  push, push_len, push_err, pop, flush, dbuf_en,
                   output count, full, head_len, head_err);
endinterface

// *** uoec_slots.sv ***
// Packet slot store holding byte count and error mark of each ready packet
`timescale 1ns/10ps
module uoec_slots #(
    parameter int CW = 11
) (
    input  wire logic  mclk,
    input  wire logic  nrst,
    uoec_slot_if.store sif
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [CW-1:0] len_q [uoec_pkg::SLOTS];
    logic [CW-1:0] len_d [uoec_pkg::SLOTS];
    logic          err_q [uoec_pkg::SLOTS];
    logic          err_d [uoec_pkg::SLOTS];
    logic          head_q;
    logic          head_d;
    logic [1:0]    count_q;
    logic [1:0]    count_d;
    logic          full_w;
    logic          do_pop;
    logic          do_push;
    logic          tail;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        full_w  = sif.dbuf_en ? (count_q == 2'h2) : (count_q != 2'h0);
        do_pop  = sif.pop && (count_q != 2'h0);
        do_push = sif.push && (!full_w || do_pop);
        len_d   = len_q;
        err_d   = err_q;
        head_d  = head_q;
        count_d = count_q;
        tail    = head_q ^ count_q[0];
        if (sif.flush) begin
            head_d  = 1'b0;
            count_d = 2'h0;
        end else begin
            if (do_push) begin
                len_d[tail] = sif.push_len;
                err_d[tail] = sif.push_err;
            end
            if (do_pop) begin
                head_d = ~head_q;
            end
            count_d = 2'(count_q + {1'b0, do_push} - {1'b0, do_pop});
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            len_q   <= '{default: '0};
            err_q   <= '{default: 1'b0};
            head_q  <= 1'b0;
            count_q <= 2'h0;
        end else begin
            len_q   <= len_d;
            err_q   <= err_d;
            head_q  <= head_d;
            count_q <= count_d;
        end
    end

    assign sif.count    = count_q;
    assign sif.full     = full_w;
    assign sif.head_len = len_q[head_q];
    assign sif.head_err = err_q[head_q];

endmodule // uoec_slots

// *** uoec_tb.sv ***
// Self-checking bench for the OUT endpoint control block
`timescale 1ns/10ps
module tb;
    localparam int W = uoec_pkg::CNT_W;
    logic               mclk = 1'b0;
    logic               nrst = 1'b0;
    logic [7:0]         reg_addr = 8'h00;
    logic [7:0]         reg_wdata = 8'h00;
    logic               reg_wr = 1'b0;
    logic               reg_rd = 1'b0;
    logic [7:0]         reg_rdata;
    logic               rx_done, rx_crc_err, hs_valid, fifo_keep, fifo_drop;
    logic               fifo_flush, clear_toggle, ep_irq, ca, cb;
    logic [W-1:0]       rx_len, la, lb;
    uoec_pkg::uoec_hs_t hs_code;
    int                 fails = 0, checked = 0, cycles = 0, seed = 30457, i;

    always #5 mclk = ~mclk;
    uoec_ctrl #(.CW(W)) dut (.mclk(mclk), .nrst(nrst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .rx_done(rx_done), .rx_len(rx_len), .rx_crc_err(rx_crc_err), .hs_valid(hs_valid),
        .hs_code(hs_code), .fifo_keep(fifo_keep), .fifo_drop(fifo_drop),
        .fifo_flush(fifo_flush), .clear_toggle(clear_toggle), .ep_irq(ep_irq));
    uoec_host_model #(.CW(W)) host (.mclk(mclk), .rx_done(rx_done), .rx_len(rx_len),
        .rx_crc_err(rx_crc_err));
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic close_out();
        $display("checked=%0d fails=%0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge mclk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= v;
        @(posedge mclk);
        reg_wr <= 1'b0;
        #1;
    endtask
    task automatic cmp_reg(input logic [7:0] a, input logic [7:0] exp);
        @(posedge mclk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        cmp(reg_rdata, exp);
    endtask
    task automatic cmp_out(input logic [5:0] exp);
        cmp({2'h0, hs_valid, hs_code, fifo_keep, fifo_drop, ep_irq}, {2'h0, exp});
    endtask
    task automatic cnt(input logic [W-1:0] l);
        cmp_reg(uoec_pkg::OFF_CNT_LOW, l[7:0]);
        cmp_reg(uoec_pkg::OFF_CNT_HIGH, {5'h00, l[10:8]});
    endtask
    task automatic tx(input logic [W-1:0] l, input logic c);
        host.pkt(l, c);
        host.idle();
        #1;
    endtask
    function automatic logic [5:0] exp_port(input logic iso, stl, crc, room);
        if (iso) return {3'h0, room, !room, 1'h1};
        if (stl) return {1'h1, uoec_pkg::UOEC_HS_STALL, 3'h3};
        if (crc) return 6'h02;
        if (!room) return {1'h1, uoec_pkg::UOEC_HS_NAK, 3'h2};
        return {1'h1, uoec_pkg::UOEC_HS_ACK, 3'h5};
    endfunction
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            close_out();
        end
    end
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        repeat (20) @(posedge mclk);
        nrst <= 1'b1;
        for (i = 0; i < 4; i++) cmp_reg(i[7:0], 8'h00);
        cmp_reg(8'h5a, 8'h00);
        // Bulk packet, then refused while full
        la = W'($random(seed));
        lb = W'($random(seed));
        tx(la, 1'h0);
        cmp_out(exp_port(1'h0, 1'h0, 1'h0, 1'h1));
        cmp_reg(8'h00, 8'h03);
        cnt(la);
        tx(lb, 1'h0);
        cmp_out(exp_port(1'h0, 1'h0, 1'h0, 1'h0));
        cnt(la);
        wr(8'h00, 8'h00);
        cmp_reg(8'h00, 8'h00);
        cnt(11'h000);
        tx(lb, 1'h1);
        cmp_out(exp_port(1'h0, 1'h0, 1'h1, 1'h1));
        cmp_reg(8'h00, 8'h00);
        // Double buffer, back to back until refused
        wr(8'h01, 8'h80);
        cmp_reg(8'h01, 8'h80);
        host.pkt(la, 1'h0);
        host.pkt(lb, 1'h0);
        tx(~la, 1'h0);
        cmp_out(exp_port(1'h0, 1'h0, 1'h0, 1'h0));
        cnt(la);
        wr(8'h00, 8'h00);
        cmp_out(6'h01);
        cmp_reg(8'h00, 8'h01);
        cnt(lb);
        wr(8'h00, 8'h00);
        // Stall
        wr(8'h00, 8'h20);
        tx(la, 1'h0);
        cmp_out(exp_port(1'h0, 1'h1, 1'h0, 1'h1));
        cmp_reg(8'h00, 8'h60);
        wr(8'h00, 8'h20);
        cmp_reg(8'h00, 8'h20);
        // Isochronous with stall bit left set
        wr(8'h01, 8'hc0);
        cmp_reg(8'h01, 8'hc0);
        for (i = 0; i < 4; i++) begin
            la = W'($random(seed));
            lb = W'($random(seed));
            ca = 1'($random(seed));
            cb = 1'($random(seed));
            tx(la, ca);
            cmp_out(exp_port(1'h1, 1'h1, ca, 1'h1));
            cmp_reg(8'h00, {4'h2, ca, 3'h1});
            tx(lb, cb);
            tx(la, cb);
            cmp_out(exp_port(1'h1, 1'h1, cb, 1'h0));
            cmp_reg(8'h00, {4'h2, ca, 3'h7});
            wr(8'h00, 8'h24);
            cmp_out(6'h01);
            cnt(lb);
            cmp_reg(8'h00, {4'h2, cb, 3'h5});
            wr(8'h00, 8'h20);
            cmp_reg(8'h00, 8'h20);
        end
        // Flush and toggle clear with a packet held
        wr(8'h00, 8'h00);
        wr(8'h01, 8'h80);
        tx(la, 1'h0);
        cmp_out(exp_port(1'h0, 1'h0, 1'h0, 1'h1));
        cmp_reg(8'h00, 8'h01);
        wr(8'h00, 8'h91);
        cmp({6'h00, fifo_flush, clear_toggle}, 8'h03);
        cmp_reg(8'h00, 8'h00);
        cnt(11'h000);
        close_out();
    end
endmodule // tb
